//--- design/pio_channel_if.sv
// Host I/O channel interface: decode, strobes, interrupt routing and DMA requests
module pio_channel_if (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [9:0] saIn,
  input wire logic aenIn,
  input wire logic iorNIn,
  input wire logic iowNIn,
  input wire logic sbheNIn,
  input wire logic [15:0] sdIn,
  output logic [15:0] sdOut,
  output logic sdOe,
  output logic iocs16NOut,
  output logic iocs16Oe,
  output logic chrdyOut,
  output logic chrdyOe,
  output logic boardSelected,
  output logic [7:0] irqOut,
  output logic [7:0] irqOe,
  output logic [7:0] drqOut,
  input wire logic [7:0] dackNIn,
  input wire logic tcIn,
  input wire logic updateExtIn,
  output logic [31:0] regSel,
  output logic rdStb,
  output logic wrStb,
  output logic xfer16,
  output logic [15:0] wrData,
  input wire logic [15:0] rdData,
  input wire logic aiFifoNotEmpty,
  input wire logic acqDone,
  input wire logic aoFifoNotFull,
  input wire logic aoSeqDone,
  input wire logic updateInt
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic [7:0] chanOneHot(input logic [2:0] ch, input logic eisa);
    logic ok;
    ok = (ch >= pio_pkg::DMA_HIGH_MIN) || (eisa && (ch <= pio_pkg::DMA_LOW_MAX));
    chanOneHot = ok ? (8'h01 << ch) : 8'h00;
  endfunction

  function automatic logic [31:0] byteMask(input logic [3:0] sel);
    byteMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // ****************************************
  // Pin synchronisation
  // ****************************************
  pio_pkg::pio_pins_t pinsRaw;
  pio_pkg::pio_pins_t pins;
  logic [pio_pkg::PINS_W-1:0] pinsSync;

  assign pinsRaw = '{sa: saIn, aen: aenIn, iorN: iorNIn, iowN: iowNIn, sbheN: sbheNIn,
                     sd: sdIn, dackN: dackNIn, tc: tcIn, updExt: updateExtIn};

  pio_sync #(.WIDTH(pio_pkg::PINS_W)) u_sync (.mclk(mclk), .arst_n(arst_n), .din(pinsRaw),
    .dout(pinsSync));

  assign pins = pio_pkg::pio_pins_t'(pinsSync);

  // ****************************************
  // Register bus
  // ****************************************
  pio_pkg::pio_cfg_t cfg;
  logic [pio_pkg::NUM_INT-1:0] intEn, intStat, intSet, intClr;
  logic [31:0] wrMask, cfgWord, next_cfg, next_rd, statusWord;
  logic wbWrite;

  assign wrMask = byteMask(wb_sel_i);
  assign wbWrite = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
  assign cfgWord = {{(32 - pio_pkg::CFG_W){1'b0}}, cfg};
  assign next_cfg = (cfgWord & ~wrMask) | (wb_dat_i & wrMask);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= pio_pkg::pio_cfg_t'(pio_pkg::CFG_RST);
      intEn <= '0;
    end else if (wbWrite) begin
      if (wb_adr_i == pio_pkg::OFS_CFG) begin
        cfg <= pio_pkg::pio_cfg_t'(next_cfg[pio_pkg::CFG_W-1:0]);
      end
      if (wb_adr_i == pio_pkg::OFS_INTEN && wb_sel_i[0]) begin
        intEn <= wb_dat_i[pio_pkg::NUM_INT-1:0];
      end
    end
  end

  assign intClr = (wbWrite && wb_adr_i == pio_pkg::OFS_INTSTAT && wb_sel_i[0]) ?
                  wb_dat_i[pio_pkg::NUM_INT-1:0] : '0;

  always_comb begin
    case (wb_adr_i)
      pio_pkg::OFS_CFG: next_rd = cfgWord;
      pio_pkg::OFS_INTEN: next_rd = {{(32 - pio_pkg::NUM_INT){1'b0}}, intEn};
      pio_pkg::OFS_INTSTAT: next_rd = {{(32 - pio_pkg::NUM_INT){1'b0}}, intStat};
      pio_pkg::OFS_STATUS: next_rd = statusWord;
      default: next_rd = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      wb_dat_o <= next_rd;
    end
  end

  // ****************************************
  // Host address decode and cycle control
  // ****************************************
  logic boardEn, hostRd, hostWr, cycleActive, cycIsRead;
  logic [3:0] waitCnt;
  pio_pkg::pio_state_t state;

  assign boardEn = !pins.aen &&
                   (pins.sa[pio_pkg::ADDR_BITS-1:pio_pkg::SEL_BITS] == cfg.base);
  assign hostRd = !pins.iorN;
  assign hostWr = !pins.iowN;
  assign cycleActive = boardEn && (hostRd || hostWr);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      boardSelected <= 1'b0;
      regSel <= '0;
      xfer16 <= 1'b0;
      iocs16NOut <= 1'b0;
      iocs16Oe <= 1'b0;
      sdOe <= 1'b0;
      sdOut <= 16'h0000;
    end else begin
      boardSelected <= boardEn;
      regSel <= boardEn ? (32'h0000_0001 << pins.sa[pio_pkg::SEL_BITS-1:0]) : '0;
      xfer16 <= !pins.sbheN && !pins.sa[0];
      iocs16Oe <= boardEn && !pins.sbheN && !pins.sa[0];
      sdOe <= boardEn && hostRd;
      sdOut <= rdData;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= pio_pkg::ST_IDLE;
      waitCnt <= 4'h0;
      cycIsRead <= 1'b0;
      chrdyOut <= 1'b0;
      chrdyOe <= 1'b0;
      rdStb <= 1'b0;
      wrStb <= 1'b0;
      wrData <= 16'h0000;
    end else begin
      rdStb <= 1'b0;
      wrStb <= 1'b0;
      case (state)
        pio_pkg::ST_IDLE: begin
          if (cycleActive) begin
            state <= pio_pkg::ST_WAIT;
            waitCnt <= pio_pkg::WAIT_CYC - 4'h1;
            cycIsRead <= hostRd;
            chrdyOe <= 1'b1;
          end
        end
        pio_pkg::ST_WAIT: begin
          if (waitCnt == 4'h0) begin
            state <= pio_pkg::ST_DONE;
            chrdyOe <= 1'b0;
            if (!cycIsRead) begin
              wrStb <= 1'b1;
              wrData <= pins.sd;
            end
          end else begin
            waitCnt <= waitCnt - 4'h1;
          end
        end
        pio_pkg::ST_DONE: begin
          if (!cycleActive) begin
            state <= pio_pkg::ST_IDLE;
            rdStb <= cycIsRead;
          end
        end
        default: begin
          state <= pio_pkg::ST_IDLE;
          chrdyOe <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Interrupt sources and routing
  // ****************************************
  logic updSel, updPrev, tcHit, tcPrev, irqAny;

  assign updSel = cfg.updExt ? pins.updExt : updateInt;
  assign tcHit = pins.tc && (!pins.dackN[cfg.chA] || (cfg.dual && !pins.dackN[cfg.chB]));

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      updPrev <= 1'b0;
      tcPrev <= 1'b0;
    end else begin
      updPrev <= updSel;
      tcPrev <= tcHit;
    end
  end

  always_comb begin
    intSet = '0;
    intSet[pio_pkg::INT_AI] = aiFifoNotEmpty;
    intSet[pio_pkg::INT_ACQ] = acqDone;
    intSet[pio_pkg::INT_TC] = tcHit && !tcPrev;
    intSet[pio_pkg::INT_AO] = aoFifoNotFull;
    intSet[pio_pkg::INT_SEQ] = aoSeqDone;
    intSet[pio_pkg::INT_UPD] = updPrev && !updSel;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      intStat <= '0;
    end else begin
      intStat <= (intStat & ~intClr) | intSet;
    end
  end

  assign irqAny = |(intStat & intEn);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irqOut <= 8'h00;
      irqOe <= 8'h00;
    end else begin
      irqOut <= irqAny ? (8'h01 << cfg.irqSel) : 8'h00;
      irqOe <= irqAny ? (8'h01 << cfg.irqSel) : 8'h00;
    end
  end

  // ****************************************
  // DMA requests
  // ****************************************
  logic aiReq, aoReq, reqA, reqB;

  assign aiReq = cfg.aiDma && aiFifoNotEmpty;
  assign aoReq = cfg.aoDma && aoFifoNotFull;
  assign reqA = cfg.dual ? aiReq : (aiReq || aoReq);
  assign reqB = cfg.dual && aoReq;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      drqOut <= 8'h00;
    end else begin
      drqOut <= (chanOneHot(cfg.chA, cfg.eisa) & {8{reqA}}) |
                (chanOneHot(cfg.chB, cfg.eisa) & {8{reqB}});
    end
  end

  assign statusWord = {27'h0000000, irqAny, |(drqOut & chanOneHot(cfg.chB, cfg.eisa)),
                       |(drqOut & chanOneHot(cfg.chA, cfg.eisa)), xfer16, boardSelected};

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  chk_data_drive: assert property (sdOe |-> $past(boardEn && hostRd))
    else $error("data driven outside a selected read");
  chk_sel_decode: assert property ($past(boardEn) |-> $onehot(regSel))
    else $error("register select not one-hot");
  chk_no_sel: assert property (!$past(boardEn) |-> regSel == '0)
    else $error("register select without board enable");
  chk_wait_len: assert property ($rose(chrdyOe) |-> chrdyOe [*2] ##1 !chrdyOe)
    else $error("ready wait length wrong");
  chk_irq_line: assert property (irqOe != 8'h00 |-> $onehot(irqOe) && irqOut == irqOe)
    else $error("interrupt line drive malformed");
  chk_irq_route: assert property ($past(irqAny) |-> irqOe[$past(cfg.irqSel)])
    else $error("interrupt not on selected line");
  chk_set_wins: assert property (intSet[pio_pkg::INT_ACQ] |=> intStat[pio_pkg::INT_ACQ])
    else $error("acquisition event lost");
  chk_upd_edge: assert property ($fell(updSel) |=> intStat[pio_pkg::INT_UPD])
    else $error("update falling edge not flagged");
  chk_dma_ch4: assert property (!drqOut[4])
    else $error("request on cascade channel");
  chk_dma_low: assert property (!$past(cfg.eisa) |-> drqOut[3:0] == 4'h0)
    else $error("low channel request without EISA");
  chk_ai_drq: assert property ($past(aiReq && !cfg.dual) && $past(cfg.chA) >= 3'h5
                               |-> drqOut[$past(cfg.chA)])
    else $error("input FIFO request missing");

  cov_read: cover property ($rose(sdOe) ##[1:20] rdStb);
  cov_write: cover property ($rose(chrdyOe) ##[1:20] wrStb);
  cov_irq: cover property ($rose(irqAny));
  cov_dual: cover property (cfg.dual && reqA && reqB);

endmodule

//--- design/pio_pkg.sv
// Package: constants, register map and carrier types of the I/O channel interface
package pio_pkg;

  // ****************************************
  // Host address decode
  // ****************************************
  localparam int ADDR_BITS = 10;
  localparam int SEL_BITS = 5;
  localparam int NUM_SEL = 32;
  localparam logic [4:0] BASE_RST = 5'h11;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAIT_NS = 20;
  localparam int WAIT_CYC_I = (WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] WAIT_CYC = 4'(WAIT_CYC_I < 1 ? 1 : WAIT_CYC_I);

  // ****************************************
  // Wishbone register map (byte addresses)
  // ****************************************
  localparam logic [3:0] OFS_CFG = 4'h0;
  localparam logic [3:0] OFS_INTEN = 4'h4;
  localparam logic [3:0] OFS_INTSTAT = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  localparam int CFG_W = 19;
  localparam logic [18:0] CFG_RST = 19'h06a11;
  localparam int NUM_INT = 6;

  // Interrupt source positions
  localparam int INT_AI = 0;
  localparam int INT_ACQ = 1;
  localparam int INT_TC = 2;
  localparam int INT_AO = 3;
  localparam int INT_SEQ = 4;
  localparam int INT_UPD = 5;

  // Status register bit positions
  localparam int ST_SEL = 0;
  localparam int ST_W16 = 1;
  localparam int ST_DRQA = 2;
  localparam int ST_DRQB = 3;
  localparam int ST_IRQ = 4;

  // DMA channel limits
  localparam logic [2:0] DMA_LOW_MAX = 3'h3;
  localparam logic [2:0] DMA_HIGH_MIN = 3'h5;

  // Configuration word
  typedef struct packed {
    logic updExt;
    logic aoDma;
    logic aiDma;
    logic eisa;
    logic [2:0] chB;
    logic [2:0] chA;
    logic dual;
    logic [2:0] irqSel;
    logic [4:0] base;
  } pio_cfg_t;

  // Asynchronous host pins as one bundle
  typedef struct packed {
    logic [9:0] sa;
    logic aen;
    logic iorN;
    logic iowN;
    logic sbheN;
    logic [15:0] sd;
    logic [7:0] dackN;
    logic tc;
    logic updExt;
  } pio_pins_t;

  localparam int PINS_W = $bits(pio_pins_t);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } pio_state_t;

endpackage

//--- design/pio_sync.sv
// Two-stage synchroniser for a bundle of asynchronous inputs
module pio_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule

//--- bench/pio_host_model.sv
// Host I/O channel and DMA controller model
module pio_host_model (
  input wire logic mclk,
  input wire logic [15:0] sdOut,
  input wire logic sdOe,
  input wire logic chrdyOe,
  output logic [9:0] saIn,
  output logic aenIn,
  output logic iorNIn,
  output logic iowNIn,
  output logic sbheNIn,
  output logic [15:0] sdIn,
  output logic [7:0] dackNIn,
  output logic tcIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] hostSd;
  // Released data lines show the inverse of the last value
  assign sdIn = sdOe ? sdOut : hostSd;
  initial begin
    saIn = 10'h000;
    aenIn = 1'b1;
    iorNIn = 1'b1;
    iowNIn = 1'b1;
    sbheNIn = 1'b1;
    hostSd = 16'h0000;
    dackNIn = 8'hff;
    tcIn = 1'b0;
  end
  task automatic io_cycle(input logic wr, input logic [9:0] a, input logic w16,
                          input logic aen, input logic [15:0] d, output logic [15:0] q);
    saIn <= a;
    aenIn <= aen;
    sbheNIn <= ~w16;
    hostSd <= wr ? d : ~hostSd;
    @(posedge mclk);
    iowNIn <= ~wr;
    iorNIn <= wr;
    repeat (6) @(posedge mclk);
    while (chrdyOe === 1'b1) begin
      @(posedge mclk);
    end
    q = sdIn;
    iorNIn <= 1'b1;
    iowNIn <= 1'b1;
    aenIn <= 1'b1;
    hostSd <= ~hostSd;
    repeat (6) @(posedge mclk);
  endtask
  task automatic dma_tc(input int ch);
    dackNIn[ch] <= 1'b0;
    tcIn <= 1'b1;
    repeat (4) @(posedge mclk);
    dackNIn <= 8'hff;
    tcIn <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
endmodule

//--- bench/tb_pio_channel_if.sv
// Testbench of the host I/O channel interface
module tb_pio_channel_if;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, e, m) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("BAD %0t %s", $time, m); end end
  logic mclk, arst_n, wbCyc, wbStb, wbWe, wbAck, sdOe, iocs16Oe, chrdyOe, boardSelected;
  logic aenIn, iorNIn, iowNIn, sbheNIn, tcIn, rdStb, wrStb, xfer16;
  logic aiFifoNotEmpty, acqDone, aoFifoNotFull, aoSeqDone, updateInt;
  logic boardSnap, cs16Snap, w16Snap, oeSnap, wrHit, rdHit, updExtPin;
  logic [7:0] rdyCnt;
  logic [3:0] wbAdr;
  logic [31:0] wbDatW, wbDatR, regSel, selSnap, rd;
  logic [9:0] saIn;
  logic [15:0] sdIn, sdOut, wrData, rdData, q, wrSnap;
  logic [7:0] irqOut, irqOe, drqOut, dackNIn;
  logic [9:0] badA [5] = '{10'h240, 10'h020, 10'h200, 10'h3e0, 10'h221};
  int error_cnt, num_checks, tick;
  pio_pkg::pio_cfg_t cfg;

  pio_channel_if i_pio_channel_if (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf),
    .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .saIn(saIn), .aenIn(aenIn),
    .iorNIn(iorNIn), .iowNIn(iowNIn), .sbheNIn(sbheNIn), .sdIn(sdIn), .sdOut(sdOut),
    .sdOe(sdOe), .iocs16NOut(), .iocs16Oe(iocs16Oe), .chrdyOut(), .chrdyOe(chrdyOe),
    .boardSelected(boardSelected), .irqOut(irqOut), .irqOe(irqOe), .drqOut(drqOut),
    .dackNIn(dackNIn), .tcIn(tcIn), .updateExtIn(updExtPin), .regSel(regSel), .rdStb(rdStb),
    .wrStb(wrStb), .xfer16(xfer16), .wrData(wrData), .rdData(rdData),
    .aiFifoNotEmpty(aiFifoNotEmpty), .acqDone(acqDone), .aoFifoNotFull(aoFifoNotFull),
    .aoSeqDone(aoSeqDone), .updateInt(updateInt));

  pio_host_model u_host (.mclk(mclk), .sdOut(sdOut), .sdOe(sdOe), .chrdyOe(chrdyOe),
    .saIn(saIn), .aenIn(aenIn), .iorNIn(iorNIn), .iowNIn(iowNIn), .sbheNIn(sbheNIn),
    .sdIn(sdIn), .dackNIn(dackNIn), .tcIn(tcIn));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ******
  // Sticky record of what the design showed during a host cycle
  // ******
  always @(posedge mclk) begin
    selSnap <= selSnap | regSel;
    boardSnap <= boardSnap | boardSelected;
    cs16Snap <= cs16Snap | iocs16Oe;
    w16Snap <= w16Snap | xfer16;
    oeSnap <= oeSnap | sdOe;
    if (wrStb) begin
      wrHit <= 1'b1;
      wrSnap <= wrData;
    end
    if (rdStb) begin
      rdHit <= 1'b1;
    end
    if (chrdyOe) begin
      rdyCnt <= rdyCnt + 8'h01;
    end
    tick <= tick + 1;
    if (tick > 5000) begin
      error_cnt++;
      report_and_stop;
    end
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatW <= d;
    do begin
      @(posedge mclk);
    end while (wbAck !== 1'b1);
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr_cfg();
    wb(1'b1, pio_pkg::OFS_CFG, 32'(cfg));
  endtask

  task automatic io(input logic wr, input logic [9:0] a, input logic w16, input logic aen,
                    input logic [15:0] d);
    @(negedge mclk);
    selSnap = '0;
    {boardSnap, cs16Snap, w16Snap, oeSnap, wrHit, rdHit} = '0;
    rdyCnt = 8'h00;
    @(posedge mclk);
    u_host.io_cycle(wr, a, w16, aen, d, q);
  endtask

  task automatic hit(input int j);
    case (j)
      0: aiFifoNotEmpty <= 1'b1;
      1: acqDone <= 1'b1;
      2: u_host.dma_tc(5);
      3: aoFifoNotFull <= 1'b1;
      4: aoSeqDone <= 1'b1;
      default: updateInt <= 1'b1;
    endcase
    @(posedge mclk);
    {aiFifoNotEmpty, acqDone, aoFifoNotFull, aoSeqDone, updateInt} <= '0;
  endtask

  task automatic dma_case(input pio_pkg::pio_cfg_t c, input logic ai, input logic ao,
                          input logic [7:0] e);
    cfg = c;
    wr_cfg();
    aiFifoNotEmpty <= ai;
    aoFifoNotFull <= ao;
    repeat (4) @(posedge mclk);
    `CHK(drqOut, e, "dma request")
    wb(1'b0, pio_pkg::OFS_STATUS, 32'h0);
    `CHK(rd[pio_pkg::ST_DRQA] | rd[pio_pkg::ST_DRQB], |e, "status request")
    {aiFifoNotEmpty, aoFifoNotFull} <= '0;
    repeat (3) @(posedge mclk);
  endtask

  initial begin
    {arst_n, wbCyc, wbStb, wbWe, aiFifoNotEmpty, acqDone, aoFifoNotFull} = '0;
    {aoSeqDone, updateInt, boardSnap, cs16Snap, w16Snap, oeSnap, wrHit, rdHit} = '0;
    updExtPin = 1'b0;
    rdyCnt = 8'h00;
    {wbAdr, wbDatW, selSnap, wrSnap} = '0;
    rdData = 16'h5a3c;
    error_cnt = 0;
    num_checks = 0;
    tick = 0;
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    wb(1'b0, pio_pkg::OFS_CFG, 32'h0);
    `CHK(rd, 32'(pio_pkg::CFG_RST), "cfg reset")
    wb(1'b1, 4'h6, 32'hffffffff);
    wb(1'b0, 4'h6, 32'h0);
    `CHK(rd, 32'h0, "unmapped read")
    $display("registers done");
    io(1'b1, 10'h222, 1'b1, 1'b0, 16'hc3a5);
    `CHK(boardSnap, 1'b1, "not selected")
    `CHK(selSnap, 32'h4, "write select")
    `CHK(cs16Snap, 1'b1, "no 16-bit ind")
    `CHK(w16Snap, 1'b1, "width")
    `CHK({wrHit, wrSnap}, {1'b1, 16'hc3a5}, "write data")
    `CHK({oeSnap, rdHit}, 2'b00, "drove on write")
    `CHK(rdyCnt, 8'(pio_pkg::WAIT_CYC), "ready wait")
    io(1'b0, 10'h23f, 1'b0, 1'b0, 16'h0);
    `CHK(q, 16'h5a3c, "read data")
    `CHK(selSnap, 32'h80000000, "read select")
    `CHK(cs16Snap, 1'b0, "8-bit ind")
    `CHK(rdHit, 1'b1, "read strobe")
    `CHK(rdyCnt, 8'(pio_pkg::WAIT_CYC), "read ready wait")
    for (int i = 0; i < 5; i++) begin
      io(1'b1, badA[i], 1'b0, i == 4, 16'h1);
      `CHK(boardSnap | wrHit | oeSnap | (|selSnap) | (|rdyCnt), 1'b0, "stray decode")
    end
    cfg = pio_pkg::CFG_RST;
    cfg.base = 5'h18;
    wr_cfg();
    io(1'b1, 10'h305, 1'b0, 1'b0, 16'h77);
    `CHK(selSnap, 32'h20, "moved base")
    io(1'b1, 10'h225, 1'b0, 1'b0, 16'h77);
    `CHK(boardSnap, 1'b0, "old base")
    $display("host cycles done");
    wb(1'b1, pio_pkg::OFS_INTEN, 32'h3f);
    for (int i = 0; i < 8; i++) begin
      cfg = pio_pkg::CFG_RST;
      cfg.irqSel = 3'(i);
      wr_cfg();
      hit(i % 6);
      repeat (4) @(posedge mclk);
      wb(1'b0, pio_pkg::OFS_INTSTAT, 32'h0);
      `CHK(rd[5:0], 6'(1 << (i % 6)), "source flag")
      `CHK({irqOe, irqOut[i]}, {8'(1 << i), 1'b1}, "irq line")
      wb(1'b1, pio_pkg::OFS_INTSTAT, 32'(1 << (i % 6)));
      wb(1'b0, pio_pkg::OFS_INTSTAT, 32'h0);
      `CHK({rd[5:0], irqOe}, 14'h0, "clear")
    end
    wb(1'b1, pio_pkg::OFS_INTEN, 32'h0);
    hit(1);
    repeat (4) @(posedge mclk);
    `CHK(irqOe, 8'h0, "masked")
    wb(1'b1, pio_pkg::OFS_INTSTAT, 32'h3f);
    cfg = pio_pkg::CFG_RST;
    cfg.updExt = 1'b1;
    wr_cfg();
    hit(5);
    updExtPin <= 1'b1;
    repeat (4) @(posedge mclk);
    wb(1'b0, pio_pkg::OFS_INTSTAT, 32'h0);
    `CHK(rd[5:0], 6'h00, "internal update taken")
    updExtPin <= 1'b0;
    repeat (4) @(posedge mclk);
    wb(1'b0, pio_pkg::OFS_INTSTAT, 32'h0);
    `CHK(rd[5:0], 6'(1 << pio_pkg::INT_UPD), "external update")
    $display("interrupts done");
    cfg = pio_pkg::CFG_RST;
    cfg.aiDma = 1'b1;
    dma_case(cfg, 1'b1, 1'b0, 8'h20);
    cfg.aoDma = 1'b1;
    dma_case(cfg, 1'b0, 1'b1, 8'h20);
    cfg.dual = 1'b1;
    dma_case(cfg, 1'b0, 1'b1, 8'h40);
    dma_case(cfg, 1'b1, 1'b0, 8'h20);
    cfg.chA = 3'h1;
    dma_case(cfg, 1'b1, 1'b0, 8'h00);
    cfg.eisa = 1'b1;
    dma_case(cfg, 1'b1, 1'b0, 8'h02);
    cfg.chA = 3'h7;
    dma_case(cfg, 1'b1, 1'b0, 8'h80);
    cfg.aiDma = 1'b0;
    dma_case(cfg, 1'b1, 1'b0, 8'h00);
    $display("dma done");
    report_and_stop;
  end
endmodule
